// ==== iwdp_defs.vh ====
// Constants for the interval watchdog reached through one I/O port.
// Assumes a 100 MHz system clock and an 8-bit I/O port bus with strobes.
`ifndef IWDP_DEFS_VH
`define IWDP_DEFS_VH
`define IWDP_PORT_ADDR     16'h0443
`define IWDP_CODE_MIN      8'h01
`define IWDP_CODE_MAX      8'h3e
`define IWDP_INTERVAL_RST  8'h00
`define IWDP_CLK_HZ        100000000
`define IWDP_TICK_SEC      1
`define IWDP_TICK_CYCLES   (`IWDP_CLK_HZ * `IWDP_TICK_SEC)
`endif

// ==== iwdp_tick_gen.v ====
// One-second tick divider for the interval watchdog.
// Assumes clk is the system clock; restart realigns the second boundary.
`timescale 1ns/100ps
`include "iwdp_defs.vh"
module iwdp_tick_gen
#(
  parameter TICK_CYCLES = `IWDP_TICK_CYCLES
)
(
  input  wire clk,
  input  wire rst,
  input  wire restart,
  output reg  tick
);
  reg [31:0] count;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= 32'h0;
      tick  <= 1'b0;
    end
    else if (restart)
    begin
      count <= 32'h0;
      tick  <= 1'b0;
    end
    else if (count == TICK_CYCLES - 1)
    begin
      count <= 32'h0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule

// ==== iwdp_watchdog.v ====
// Interval watchdog behind a single byte-wide I/O port.
// Assumes ioWr/ioRd are one-cycle strobes synchronous to clk with a stable address.
`timescale 1ns/100ps
`include "iwdp_defs.vh"
module iwdp_watchdog
#(
  parameter TICK_CYCLES = `IWDP_TICK_CYCLES
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] ioAddr,
  input  wire [7:0]  ioWrData,
  input  wire        ioWr,
  input  wire        ioRd,
  input  wire        strapResetEn,
  input  wire        strapLedEn,
  input  wire        strapDoLink,
  input  wire        normalDo7,
  output reg  [7:0]  ioRdData,
  output reg         ioRdValid,
  output reg         timeout,
  output reg         active,
  output reg         sysResetReq,
  output reg         frontLed,
  output reg         digital_output_bit7
);
  localparam [1:0] ST_IDLE    = 2'b00;
  localparam [1:0] ST_COUNT   = 2'b01;
  localparam [1:0] ST_EXPIRED = 2'b10;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [7:0] count;
  reg  [7:0] next_count;
  reg  [7:0] interval;
  reg  [7:0] next_interval;
  reg        next_active;
  reg        next_timeout;
  reg        strapResetS1;
  reg        strapResetS2;
  reg        strapLedS1;
  reg        strapLedS2;
  reg        strapDoS1;
  reg        strapDoS2;
  wire       tick;
  wire       wrHit;
  wire       rdHit;
  wire [7:0] code;

  // Both strobes decode the same port address, so the match is written once.
  function port_match;
    input [15:0] addr;
    input        strobe;
    begin
      port_match = (addr == `IWDP_PORT_ADDR) & strobe;
    end
  endfunction

  // Out-of-range codes are clamped so a bad write never gives a zero or overlong interval.
  function [7:0] clamp_code;
    input [7:0] raw;
    begin
      if (raw < `IWDP_CODE_MIN)
        clamp_code = `IWDP_CODE_MIN;
      else if (raw > `IWDP_CODE_MAX)
        clamp_code = `IWDP_CODE_MAX;
      else
        clamp_code = raw;
    end
  endfunction

  assign wrHit = port_match(ioAddr, ioWr);
  assign rdHit = port_match(ioAddr, ioRd);
  assign code  = clamp_code(ioWrData);

  iwdp_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .clk     (clk),
    .rst     (rst),
    .restart (wrHit),
    .tick    (tick)
  );

  // Straps are board jumpers with no relation to clk, so each passes two flip-flops.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strapResetS1 <= 1'b0;
      strapResetS2 <= 1'b0;
    end
    else
    begin
      strapResetS1 <= strapResetEn;
      strapResetS2 <= strapResetS1;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strapLedS1 <= 1'b0;
      strapLedS2 <= 1'b0;
    end
    else
    begin
      strapLedS1 <= strapLedEn;
      strapLedS2 <= strapLedS1;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strapDoS1 <= 1'b0;
      strapDoS2 <= 1'b0;
    end
    else
    begin
      strapDoS1 <= strapDoLink;
      strapDoS2 <= strapDoS1;
    end
  end

  // A write beats a read in the same cycle, and either one withdraws a pending timeout.
  always @*
  begin
    next_state    = state;
    next_count    = count;
    next_interval = interval;
    next_timeout  = timeout;
    if (wrHit)
    begin
      next_state    = ST_COUNT;
      next_count    = code;
      next_interval = code;
      next_timeout  = 1'b0;
    end
    else if (rdHit)
    begin
      next_state   = ST_IDLE;
      next_timeout = 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          next_state = ST_IDLE;
        end
        ST_COUNT:
        begin
          if (tick)
          begin
            next_count = count - 8'h01;
            if (count == 8'h01)
            begin
              next_state   = ST_EXPIRED;
              next_timeout = 1'b1;
            end
          end
        end
        ST_EXPIRED:
        begin
          next_timeout = 1'b1;
        end
        default:
        begin
          next_state   = ST_IDLE;
          next_timeout = 1'b0;
        end
      endcase
    end
    next_active = (next_state == ST_COUNT);
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state    <= ST_IDLE;
      count    <= `IWDP_INTERVAL_RST;
      interval <= `IWDP_INTERVAL_RST;
      active   <= 1'b0;
      timeout  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      count    <= next_count;
      interval <= next_interval;
      active   <= next_active;
      timeout  <= next_timeout;
    end
  end

  // The read answer is a one-cycle pulse; data returns to zero so a stale code is never seen.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ioRdData  <= 8'h00;
      ioRdValid <= 1'b0;
    end
    else
    begin
      ioRdValid <= rdHit;
      ioRdData  <= rdHit ? interval : 8'h00;
    end
  end

  // Routing adds one cycle after timeout, which a system reset can easily afford.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sysResetReq         <= 1'b0;
      frontLed            <= 1'b0;
      digital_output_bit7 <= 1'b0;
    end
    else
    begin
      sysResetReq         <= timeout & strapResetS2;
      frontLed            <= timeout & strapLedS2;
      digital_output_bit7 <= strapDoS2 ? timeout : normalDo7;
    end
  end
endmodule

// ==== iwdp_props_properties.sv ====
// Checker for the watchdog port.
// Bound to iwdp_watchdog; sees its ports.
`timescale 1ns/100ps
module iwdp_props
(
  input wire        clk,
  input wire        rst,
  input wire [15:0] ioAddr,
  input wire        ioWr,
  input wire        ioRd,
  input wire [7:0]  ioRdData,
  input wire        ioRdValid,
  input wire        timeout,
  input wire        active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire hit = ioAddr == 16'h0443;
  write_start_a: assert property (ioWr && hit |=> active && !timeout) else $error("start");
  read_stop_a: assert property (ioRd && !ioWr && hit |=> ioRdValid && !active && !timeout) else $error("stop");
  code_range_a: assert property (ioRdValid |-> ioRdData <= 8'h3e) else $error("code");
  idle_start_a: assert property ($rose(active) |-> $past(ioWr)) else $error("idle");
  expiry_cause_a: assert property ($rose(timeout) |-> $past(active)) else $error("expiry");
  flag_hold_a: assert property (timeout && !ioWr && !ioRd |=> timeout && !active) else $error("hold");
endmodule
bind iwdp_watchdog iwdp_props chk (.*);

// ==== iwdp_host.sv ====
// Host model for the watchdog port.
// Drives one-cycle strobes 1 ns after clk.
`timescale 1ns/100ps
module iwdp_host
(
  input wire        clk,
  output reg [15:0] ioAddr = 16'h0,
  output reg [7:0]  ioWrData = 8'h0,
  output reg        ioWr = 1'b0,
  output reg        ioRd = 1'b0
);
  task acc(input [15:0] a, input [7:0] d, input w);
    begin
      @(posedge clk) #1;
      ioAddr = a;
      ioWrData = d;
      ioWr = w;
      ioRd = !w;
      @(posedge clk) #1;
      ioWr = 1'b0;
      ioRd = 1'b0;
      ioWrData = ~d;
    end
  endtask
endmodule

// ==== interval_watchdog_port_tb.sv ====
// Bench for the watchdog port.
// Short tick of 10 cycles so expiry takes 11 to 621 cycles.
`timescale 1ns/100ps
module interval_watchdog_port_tb;
  localparam  TICKS = 10;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         strapResetEn = 1'b1;
  reg         strapLedEn = 1'b1;
  reg         strapDoLink = 1'b1;
  reg         normalDo7 = 1'b0;
  wire [15:0] ioAddr;
  wire [7:0]  ioWrData;
  wire [7:0]  ioRdData;
  wire        ioWr;
  wire        ioRd;
  wire        ioRdValid;
  wire        timeout;
  wire        active;
  wire        sysResetReq;
  wire        frontLed;
  wire        digital_output_bit7;
  integer     mismatches = 0;
  integer     n_tests = 0;
  integer     i;
  integer     n;
  initial
  begin
    forever #5 clk = ~clk;
  end
  iwdp_host host
  (
    .clk      (clk),
    .ioAddr   (ioAddr),
    .ioWrData (ioWrData),
    .ioWr     (ioWr),
    .ioRd     (ioRd)
  );
  iwdp_watchdog #(.TICK_CYCLES(TICKS)) uut
  (
    .clk                 (clk),
    .rst                 (rst),
    .ioAddr              (ioAddr),
    .ioWrData            (ioWrData),
    .ioWr                (ioWr),
    .ioRd                (ioRd),
    .strapResetEn        (strapResetEn),
    .strapLedEn          (strapLedEn),
    .strapDoLink         (strapDoLink),
    .normalDo7           (normalDo7),
    .ioRdData            (ioRdData),
    .ioRdValid           (ioRdValid),
    .timeout             (timeout),
    .active              (active),
    .sysResetReq         (sysResetReq),
    .frontLed            (frontLed),
    .digital_output_bit7 (digital_output_bit7)
  );
  function [7:0] clampc(input [7:0] c);
    clampc = c == 8'h0 ? 8'h01 : (c > 8'h3e ? 8'h3e : c);
  endfunction
  function [7:0] pins_exp(input t);
    pins_exp = {5'h00, t & strapLedEn, t & strapResetEn, strapDoLink ? t : normalDo7};
  endfunction
  task chk_cycles(input integer got, input integer want);
    begin
      n_tests = n_tests + 1;
      if (got !== want)
      begin
        mismatches = mismatches + 1;
        $display("BAD %0t %h %h", $time, got, want);
      end
      $display("test %0d done", n_tests);
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("BAD %0t %h %h", $time, got, exp);
      end
      $display("test %0d done", n_tests);
    end
  endtask
  task tally_and_finish;
    begin
      $display("tests %0d bad %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Expiry shows one cycle after the last tick, because timeout is registered on the edge that sees the tick.
  task runout(input [7:0] c);
    begin
      host.acc(16'h0443, c, 1'b1);
      i = 0;
      while (timeout !== 1'b1 && i < 800)
      begin
        @(posedge clk) #1;
        i = i + 1;
      end
      if (i == 800)
      begin
        mismatches = mismatches + 1;
        $display("BAD %0t %h %h", $time, i, clampc(c) * TICKS + 1);
        disable top_seq.scenarios;
      end
      chk_cycles(i, clampc(c) * TICKS + 1);
      @(posedge clk) #1;
      chk({5'h00, frontLed, sysResetReq, digital_output_bit7}, pins_exp(1'b1));
    end
  endtask
  initial
  begin : top_seq
    begin : scenarios
      n = $urandom(58139);
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      chk({6'h00, active, timeout}, 8'h00);
      runout(8'h00);
      runout(8'h3e);
      n = $urandom % 64;
      runout(n[7:0]);
      host.acc(16'h0444, 8'h05, 1'b1);
      chk({6'h00, active, timeout}, 8'h01);
      repeat (7) host.acc(16'h0443, 8'h01, 1'b1);
      chk({6'h00, active, timeout}, 8'h02);
      host.acc(16'h0443, 8'h50, 1'b1);
      host.acc(16'h0443, 8'h00, 1'b0);
      chk({5'h00, ioRdValid, active, timeout}, 8'h04);
      chk(ioRdData, clampc(8'h50));
      host.acc(16'h0443, 8'h02, 1'b1);
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      chk({6'h00, active, timeout}, 8'h00);
      repeat (40) @(posedge clk);
      #1;
      chk({6'h00, active, timeout}, 8'h00);
      n = $urandom;
      strapResetEn = 1'b0;
      strapLedEn = n[0];
      strapDoLink = 1'b0;
      normalDo7 = n[1];
      repeat (3) @(posedge clk);
      #1;
      chk({5'h00, frontLed, sysResetReq, digital_output_bit7}, pins_exp(1'b0));
      runout(n[15:8]);
    end
    tally_and_finish;
  end
endmodule
